// ---- verilog/return_rotate_pkg.sv ----
// Constants, encodings and carrier types for the return and rotate unit.
// Assumes a core that feeds one instruction word per four-phase cycle.
package return_rotate_pkg;

  // Phases of one instruction cycle, one clk each
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_t;

  typedef enum logic [2:0] {
    OP_IDLE      = 3'b000,
    OP_RET_IMM   = 3'b001,
    OP_RETURN    = 3'b010,
    OP_ROT_LEFT  = 3'b011,
    OP_ROT_RIGHT = 3'b100,
    OP_OTHER     = 3'b101
  } op_t;

  // Encodings
  localparam logic [3:0]  RET_IMM_TOP   = 4'hD;
  localparam logic [13:0] RETURN_WORD   = 14'h0008;
  localparam logic [5:0]  ROT_LEFT_TOP  = 6'h0D;
  localparam logic [5:0]  ROT_RIGHT_TOP = 6'h0C;

  // Field positions
  localparam int RET_IMM_TOP_LSB = 10;
  localparam int ROT_TOP_LSB     = 8;
  localparam int DEST_BIT        = 7;
  localparam int IMM_MSB         = 7;
  localparam int FILE_IDX_MSB    = 6;

  // Destination select values
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Cycle counts (instruction cycles)
  localparam int RET_CYCLES = 2;
  localparam int ROT_CYCLES = 1;

  // Values after reset
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic        CARRY_RST = 1'b0;
  localparam logic [12:0] PC_RST    = 13'h0000;
  localparam logic [13:0] INSTR_RST = 14'h0000;
  localparam logic [7:0]  IMM_RST   = 8'h00;

  typedef struct packed {
    logic       rdEn;
    logic       wrEn;
    logic [6:0] addr;
    logic [7:0] wrData;
  } file_port_t;

  typedef struct packed {
    logic        pop;
    logic        pcLoad;
    logic [12:0] pc;
  } stack_port_t;

  typedef struct packed {
    phase_t      phase;
    logic        cycleIdx;
    op_t         op;
    logic [13:0] instr;
    logic [7:0]  imm;
    logic [7:0]  acc;
    logic        carry;
    file_port_t  file;
    stack_port_t stk;
    logic        taken;
    logic        done;
    logic        unknownOp;
  } core_state_t;

endpackage

// ---- verilog/shift_thru_carry.sv ----
// One-bit rotate of a byte through a carry bit, purely combinational.
// Assumes the caller registers both results.
`timescale 1ns/1ps
`default_nettype none
module shift_thru_carry (
  // Operand
  input  wire logic [7:0] operand,
  input  wire logic       carryIn,
  input  wire logic       toLeft,
  // Result
  output logic [7:0]      result,
  output logic            carryOut
);

  always_comb begin
    if (toLeft) begin
      result   = {operand[6:0], carryIn}; // RQ7
      carryOut = operand[7]; // RQ7
    end else begin
      result   = {carryIn, operand[7:1]}; // RQ7
      carryOut = operand[0]; // RQ7
    end
  end

endmodule
`default_nettype wire

// ---- verilog/return_rotate_ops.sv ----
// Execution of immediate return, plain return and rotates through carry.
// Assumes a register file that answers a Q2 read in Q3, and a stack whose
// top entry is valid whenever this block pops it.
//
// Contract
// (RQ1) Return with immediate puts the immediate in the accumulator, loads the program counter from the stack top, takes two cycles and leaves flags alone.
// (RQ2) Plain return pops the stack top into the program counter over two cycles, the second idle, with no flag change.
// (RQ3) Rotate left shifts the addressed register left through carry in one cycle, changing only carry.
// (RQ4) Rotate right shifts the addressed register right through carry in one cycle, changing only carry.
// (RQ5) A rotate writes the accumulator when the destination bit is 0 and the register when it is 1.
// (RQ6) A rotate decodes in Q1, reads in Q2, computes in Q3 and writes in Q4.
// (RQ7) Left rotate feeds old carry to bit 0 and bit 7 to carry; right feeds old carry to bit 7 and bit 0 to carry.
`timescale 1ns/1ps
`default_nettype none
module return_rotate_ops (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // Instruction in
  input  wire logic                          instrValid,
  input  wire logic [13:0]                   instrWord,
  // Register file read data and stack top
  input  wire logic [7:0]                    fileRdData,
  input  wire logic [12:0]                   stack_top_entry,
  // Register file and stack requests
  output return_rotate_pkg::file_port_t      filePort,
  output return_rotate_pkg::stack_port_t     stackPort,
  // Core state and status
  output return_rotate_pkg::phase_t          phase,
  output logic [7:0]                         accumulator,
  output logic                               carryFlag,
  output logic                               instrTaken,
  output logic                               instrDone,
  output logic                               unknownOp
);
  import return_rotate_pkg::*;

  core_state_t state_reg;
  core_state_t state_next;
  logic [7:0]  rotResult;
  logic        rotCarry;
  logic        isRot;
  logic        isRet;
  logic        lastCycle;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic op_t decode_op(input logic [13:0] w);
    op_t o;
    o = OP_OTHER;
    if (w[13:RET_IMM_TOP_LSB] == RET_IMM_TOP) begin
      o = OP_RET_IMM; // RQ1
    end else if (w == RETURN_WORD) begin
      o = OP_RETURN; // RQ2
    end else if (w[13:ROT_TOP_LSB] == ROT_LEFT_TOP) begin
      o = OP_ROT_LEFT; // RQ3
    end else if (w[13:ROT_TOP_LSB] == ROT_RIGHT_TOP) begin
      o = OP_ROT_RIGHT; // RQ4
    end
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Rotate datapath

  shift_thru_carry u_rot (
    .operand  (fileRdData),
    .carryIn  (state_reg.carry),
    .toLeft   (state_reg.op == OP_ROT_LEFT),
    .result   (rotResult),
    .carryOut (rotCarry)
  );

  assign isRot = (state_reg.op == OP_ROT_LEFT) ||
                 (state_reg.op == OP_ROT_RIGHT);
  assign isRet = (state_reg.op == OP_RET_IMM) ||
                 (state_reg.op == OP_RETURN);
  // Returns finish on their second cycle, rotates on their first
  assign lastCycle = isRet ?
    (state_reg.cycleIdx == 1'(RET_CYCLES - 1)) :
    (state_reg.cycleIdx == 1'(ROT_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_next             = state_reg;
    state_next.file.rdEn   = 1'b0;
    state_next.file.wrEn   = 1'b0;
    state_next.stk.pop     = 1'b0;
    state_next.stk.pcLoad  = 1'b0;
    state_next.taken       = 1'b0;
    state_next.done        = 1'b0;
    state_next.unknownOp   = 1'b0;
    case (state_reg.phase)
      PH_Q1: begin
        state_next.phase = PH_Q2;
        // No new word is taken during a return's idle second cycle
        if (state_reg.cycleIdx == 1'b0) begin
          state_next.op = OP_IDLE;
          if (instrValid) begin
            state_next.instr     = instrWord;
            state_next.op        = decode_op(instrWord); // RQ6
            state_next.taken     = 1'b1;
            state_next.unknownOp = (decode_op(instrWord) == OP_OTHER);
            state_next.file.addr = instrWord[FILE_IDX_MSB:0];
            state_next.file.rdEn =
              (decode_op(instrWord) == OP_ROT_LEFT) ||
              (decode_op(instrWord) == OP_ROT_RIGHT); // RQ6
          end
        end
      end
      PH_Q2: begin
        state_next.phase = PH_Q3;
        if (state_reg.op == OP_RET_IMM && state_reg.cycleIdx == 1'b0) begin
          state_next.imm = state_reg.instr[IMM_MSB:0]; // RQ1
        end
      end
      PH_Q3: begin
        state_next.phase = PH_Q4;
        if (isRot) begin
          // Only carry among the flags moves
          state_next.carry = rotCarry; // RQ3 RQ4 RQ6
          if (state_reg.instr[DEST_BIT] == DEST_ACC) begin
            state_next.acc = rotResult; // RQ5
          end else begin
            state_next.file.wrEn   = 1'b1; // RQ5 RQ6
            state_next.file.wrData = rotResult; // RQ5
          end
        end
        if (isRet && state_reg.cycleIdx == 1'b0) begin
          state_next.stk.pop    = 1'b1; // RQ1 RQ2
          state_next.stk.pcLoad = 1'b1; // RQ1 RQ2
          state_next.stk.pc     = stack_top_entry; // RQ1 RQ2
          if (state_reg.op == OP_RET_IMM) begin
            state_next.acc = state_reg.imm; // RQ1
          end
        end
        state_next.done = (isRot || isRet) && lastCycle;
      end
      default: begin
        state_next.phase = PH_Q1;
        // Returns spend one more cycle doing nothing
        state_next.cycleIdx = isRet && !lastCycle; // RQ1 RQ2
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg.phase     <= PH_Q1;
      state_reg.cycleIdx  <= 1'b0;
      state_reg.op        <= OP_IDLE;
      state_reg.instr     <= INSTR_RST;
      state_reg.imm       <= IMM_RST;
      state_reg.acc       <= ACC_RST;
      state_reg.carry     <= CARRY_RST;
      state_reg.file      <= '0;
      state_reg.stk.pop   <= 1'b0;
      state_reg.stk.pcLoad <= 1'b0;
      state_reg.stk.pc    <= PC_RST;
      state_reg.taken     <= 1'b0;
      state_reg.done      <= 1'b0;
      state_reg.unknownOp <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state flops

  assign filePort    = state_reg.file;
  assign stackPort   = state_reg.stk;
  assign phase       = state_reg.phase;
  assign accumulator = state_reg.acc;
  assign carryFlag   = state_reg.carry;
  assign instrTaken  = state_reg.taken;
  assign instrDone   = state_reg.done;
  assign unknownOp   = state_reg.unknownOp;

endmodule
`default_nettype wire

// ---- tb/return_rotate_sva.sv ----
// Checker for the return and rotate unit.
// Assumes the unit's own ports, bound below.
`timescale 1ns/1ps
`default_nettype none
module return_rotate_sva (
  // Inputs of the unit
  input wire logic                           clk,
  input wire logic                           sys_rst,
  input wire logic                           instrValid,
  input wire logic [13:0]                    instrWord,
  input wire logic [7:0]                     fileRdData,
  input wire logic [12:0]                    stack_top_entry,
  // Outputs of the unit
  input wire return_rotate_pkg::file_port_t  filePort,
  input wire return_rotate_pkg::stack_port_t stackPort,
  input wire return_rotate_pkg::phase_t      phase,
  input wire logic [7:0]                     accumulator,
  input wire logic                           carryFlag,
  input wire logic                           instrTaken,
  input wire logic                           instrDone,
  input wire logic                           unknownOp
);
  import return_rotate_pkg::*;
  logic isRot;
  logic isRet;
  logic isImm;
  assign isImm = instrWord[13:10] == RET_IMM_TOP;
  assign isRet = isImm || instrWord == RETURN_WORD;
  assign isRot = instrWord[13:9] == ROT_RIGHT_TOP[5:1];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence rotTake;
    instrTaken && $past(isRot);
  endsequence
  sequence retTake;
    instrTaken && $past(isRet);
  endsequence
  sequence popThenDone;
    stackPort.pop && stackPort.pcLoad
      && stackPort.pc == $past(stack_top_entry) ##4 instrDone;
  endsequence
  property rotResult;
    logic l, c;
    logic [7:0] v;
    (rotTake, l = $past(instrWord[8]), c = carryFlag) ##1 (1'b1, v = fileRdData)
      |-> ##1 carryFlag == (l ? v[7] : v[0]) && (filePort.wrEn ? filePort.wrData
      : accumulator) == (l ? {v[6:0], c} : {c, v[7:1]});
  endproperty
  property rotDest;
    logic d;
    (rotTake, d = $past(instrWord[DEST_BIT])) |-> ##2 filePort.wrEn == d;
  endproperty
  property immLoad;
    logic [7:0] k;
    (instrTaken && $past(isImm), k = $past(instrWord[7:0]))
      |-> ##2 accumulator == k;
  endproperty
  rot_read_a: assert property (rotTake |-> filePort.rdEn
    && filePort.addr == $past(instrWord[6:0])) else $error("rotate read");
  rot_done_a: assert property (rotTake |-> !instrDone ##2 instrDone)
    else $error("rotate length");
  ret_pop_a: assert property (retTake |-> ##2 popThenDone)
    else $error("return pop");
  ret_flags_a: assert property (retTake |-> $stable(carryFlag)[*7])
    else $error("return flags");
  imm_load_a: assert property (immLoad) else $error("immediate");
  rot_dest_a: assert property (rotDest) else $error("rotate dest");
  rot_value_a: assert property (rotResult) else $error("rotate value");
  take_q1_a: assert property (instrTaken |-> $past(instrValid)
    && $past(phase == PH_Q1)) else $error("take slot");
  unk_flag_a: assert property (unknownOp ==
    (instrTaken && !$past(isRot || isRet))) else $error("unknown word");
endmodule
bind return_rotate_ops return_rotate_sva chk (.clk(clk), .sys_rst(sys_rst),
  .instrValid(instrValid), .instrWord(instrWord), .fileRdData(fileRdData),
  .stack_top_entry(stack_top_entry), .filePort(filePort),
  .stackPort(stackPort), .phase(phase), .accumulator(accumulator),
  .carryFlag(carryFlag), .instrTaken(instrTaken), .instrDone(instrDone),
  .unknownOp(unknownOp));
`default_nettype wire

// ---- tb/return_and_rotate_ops_bench.sv ----
// Bench for the return and rotate unit.
// Drives every port itself; no far-side model.
`timescale 1ns/1ps
`default_nettype none
module return_and_rotate_ops_bench;
  import return_rotate_pkg::*;
  logic        clk, sys_rst, instrValid, carryFlag, expC;
  logic [13:0] instrWord;
  logic [7:0]  fileRdData, accumulator, expAcc;
  logic [12:0] stackTop;
  logic        instrTaken, instrDone, unknownOp;
  file_port_t  filePort;
  stack_port_t stackPort;
  phase_t      phase;
  int          nErrors = 0;
  int          checks = 0;
  return_rotate_ops DUT (.clk(clk), .sys_rst(sys_rst),
    .instrValid(instrValid), .instrWord(instrWord), .fileRdData(fileRdData),
    .stack_top_entry(stackTop), .filePort(filePort), .stackPort(stackPort),
    .phase(phase), .accumulator(accumulator), .carryFlag(carryFlag),
    .instrTaken(instrTaken), .instrDone(instrDone), .unknownOp(unknownOp));
  task automatic chk(string nm, logic [12:0] exp, logic [12:0] got);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Offer w for the coming Q1 only
  task automatic issue(logic [13:0] w, logic unk);
    while (phase !== PH_Q4) @(negedge clk);
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= w;
    @(posedge clk);
    instrValid <= 1'b0;
    @(negedge clk);
    chk("taken", 1, instrTaken);
    chk("unknown", unk, unknownOp);
  endtask
  task automatic rot(logic [13:0] w, logic [7:0] d);
    logic [7:0] r;
    logic       nc;
    r = w[8] ? {d[6:0], expC} : {expC, d[7:1]};
    nc = w[8] ? d[7] : d[0];
    issue(w, 1'b0);
    chk("rdEn", 1, filePort.rdEn);
    chk("addr", w[6:0], filePort.addr);
    @(posedge clk);
    fileRdData <= d;
    // Inverted once the read slot is over
    @(posedge clk);
    fileRdData <= ~d;
    @(negedge clk);
    chk("carry", nc, carryFlag);
    chk("done", 1, instrDone);
    chk("wrEn", w[7], filePort.wrEn);
    if (w[7])
      chk("wrData", r, filePort.wrData);
    else
      expAcc = r;
    chk("acc", expAcc, accumulator);
    expC = nc;
    $display("rotate %h ended", w);
  endtask
  task automatic ret(logic [13:0] w, logic [12:0] top);
    issue(w, 1'b0);
    @(posedge clk);
    stackTop <= top;
    @(posedge clk);
    stackTop <= ~top;
    @(negedge clk);
    chk("pop", 1, stackPort.pop & stackPort.pcLoad);
    chk("pc", top, stackPort.pc);
    if (w[13:12] == 2'b11)
      expAcc = w[7:0];
    chk("acc", expAcc, accumulator);
    // A word offered in the idle cycle must be ignored
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= 14'h0D80;
    @(posedge clk);
    instrValid <= 1'b0;
    @(negedge clk);
    chk("idle", 0, instrTaken);
    repeat (2) @(negedge clk);
    chk("done", 1, instrDone);
    chk("carry", expC, carryFlag);
    $display("return %h ended", w);
  endtask
  // Reset in mid-run must bring phase, accumulator, carry and stack pc back
  task automatic reset_mid();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("rstPhase", PH_Q1, phase);
    chk("rstAcc", ACC_RST, accumulator);
    chk("rstCarry", CARRY_RST, carryFlag);
    chk("rstPc", PC_RST, stackPort.pc);
    expAcc = ACC_RST;
    expC = CARRY_RST;
    $display("reset ended");
  endtask
  // A word that is none of the four must leave accumulator and carry alone and start no read, write or pop
  task automatic other(logic [13:0] w);
    issue(w, 1'b1);
    chk("otherRd", 0, filePort.rdEn);
    repeat (2) @(negedge clk);
    chk("otherDone", 0, instrDone);
    chk("otherWr", 0, filePort.wrEn);
    chk("otherPop", 0, stackPort.pop);
    chk("otherAcc", expAcc, accumulator);
    chk("otherCarry", expC, carryFlag);
    $display("other %h ended", w);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // About 54 clock cycles of work; 400 leaves ample margin
  initial begin
    #20000;
    nErrors++;
    stop_test();
  end
  initial begin
    sys_rst = 1'b1;
    instrValid = 1'b0;
    instrWord = 14'h0000;
    fileRdData = 8'h00;
    stackTop = 13'h0000;
    expAcc = 8'h00;
    expC = 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rot(14'h0D25, 8'hE6);
    rot(14'h0CFF, 8'hE6);
    rot(14'h0D80, 8'h81);
    ret(14'h375A, 13'h1ABC);
    ret(14'h0008, 13'h0123);
    reset_mid();
    other(14'h0000);
    rot(14'h0C11, 8'h03);
    stop_test();
  end
endmodule
`default_nettype wire
